// ### core/iot_pkg.sv
/*
 * iot_pkg: constants and carrier types for the processor i/o support block
 * (discretes, two interval timers, storage write-protect ram).
 * assumes a single 125 MHz clock and an ahb-lite register bus.
 */
// Function
// - six discrete outputs from software holding register
// - eight discrete inputs synchronized, read together
// - two interval timers, 16-bit up-counters
// - timer one 10 us, timer two 100 us
// - both timers loadable by software writes
// - timer two count readable by software
// - wrap FFFF to 0000 raises masked request
// - unloaded timer requests every full wrap
// - power up: all memory write protected
// - lower bank processor, upper bank dma
// - software reads/writes single protect bits
// - bit one blocks writes, zero allows
// - processor bit n covers words n*1024 up
// - dma bit 64+n checks dma writes only
// - 16-bit interrupt mask gates timer requests
package iot_pkg;
    localparam int          CLK_MHZ        = 125;
    localparam int          TMR1_TICK_US   = 10;
    localparam int          TMR2_TICK_US   = 100;
    localparam int          TMR1_CYCLES    = TMR1_TICK_US * CLK_MHZ;
    localparam int          TMR2_CYCLES    = TMR2_TICK_US * CLK_MHZ;
    localparam int          DOUT_W         = 6;
    localparam int          DIN_W          = 8;
    localparam int          TMR_W          = 16;
    localparam int          PROT_ADDR_W    = 7;
    localparam int          PROT_DEPTH     = 128;
    localparam int          BLOCK_SHIFT    = 10;
    localparam int          MASK_TMR1_BIT  = 9;
    localparam int          MASK_TMR2_BIT  = 7;
    // register byte offsets
    localparam logic [11:0] OFS_DOUT       = 12'h000;
    localparam logic [11:0] OFS_DIN        = 12'h004;
    localparam logic [11:0] OFS_TMR1       = 12'h008;
    localparam logic [11:0] OFS_TMR2       = 12'h00C;
    localparam logic [11:0] OFS_MASK       = 12'h010;
    localparam logic [11:0] OFS_PROT_CTRL  = 12'h014;
    localparam logic [11:0] OFS_PROT_BASE  = 12'h200;
    localparam logic [11:0] OFS_PROT_END   = 12'h3FC;
    localparam logic [5:0]  DOUT_RST       = 6'h00;
    localparam logic [15:0] MASK_RST       = 16'h0000;
    localparam logic [15:0] TMR_RST        = 16'h0000;
    localparam logic [15:0] TMR_ONES       = 16'hFFFF;
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;

    typedef enum logic [1:0] {IOT_ST_IDLE, IOT_ST_WDATA, IOT_ST_RWAIT, IOT_ST_RDATA} iot_bus_st_t;

    // memory write request under check
    typedef struct packed {
        logic        valid;
        logic        dma;
        logic [15:0] addr;
    } iot_wreq_t;

    // address phase latched by the slave
    typedef struct packed {
        logic        write;
        logic [11:0] addr;
    } iot_aphase_t;
endpackage

// ### core/iot_prot_ram.sv
/*
 * iot_prot_ram: 128 x 1 storage-protect memory, one software port and
 * one check port; both read results come out of registers.
 * assumes the owner holds the protection enable low until loaded.
 */
`timescale 1ns/10ps
module iot_prot_ram
    import iot_pkg::*;
(
    input  wire logic                   core_clk_in,
    input  wire logic                   reset_n_in,
    input  wire logic                   sw_we_in,
    input  wire logic [PROT_ADDR_W-1:0] sw_addr_in,
    input  wire logic                   sw_wdata_in,
    output logic                        sw_rdata_out,
    input  wire logic [PROT_ADDR_W-1:0] chk_addr_in,
    output logic                        chk_bit_out
);
    logic [PROT_DEPTH-1:0] bits_reg;

    // reset fills with ones: everything protected until software clears
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bits_reg <= '1;
        end else if (sw_we_in) begin
            bits_reg[sw_addr_in] <= sw_wdata_in;
        end
    end

    // registered read ports
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sw_rdata_out <= 1'b1;
            chk_bit_out  <= 1'b1;
        end else begin
            sw_rdata_out <= bits_reg[sw_addr_in];
            chk_bit_out  <= bits_reg[chk_addr_in];
        end
    end
endmodule // iot_prot_ram

// ### core/iot_top.sv
/*
 * iot_top: discrete i/o, two interval timers and the memory write
 * protection check, reached by software over ahb-lite.
 * assumes one clock, single word transfers, inputs synchronous to clock.
 */
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
module iot_top
    import iot_pkg::*;
(
    input  wire logic               core_clk_in,
    input  wire logic               reset_n_in,
    input  wire logic               hsel_in,
    input  wire logic [31:0]        haddr_in,
    input  wire logic [1:0]         htrans_in,
    input  wire logic               hwrite_in,
    input  wire logic [2:0]         hsize_in,
    input  wire logic [31:0]        hwdata_in,
    input  wire logic               hready_in,
    output logic [31:0]             hrdata_out,
    output logic                    hreadyout_out,
    output logic                    hresp_out,
    input  wire logic [DIN_W-1:0]   bus_interface_unit_din_in,
    output logic [DOUT_W-1:0]       bus_interface_unit_dout_out,
    output logic                    tmr1_irq_out,
    output logic                    tmr2_irq_out,
    input  wire iot_wreq_t          mem_wreq_in,
    output logic                    mem_we_out,
    output logic                    mem_block_out
);
    iot_bus_st_t          st_reg;
    iot_aphase_t          ap_reg;
    logic [DOUT_W-1:0]    dout_reg;
    logic [DIN_W-1:0]     din_meta_reg;
    logic [DIN_W-1:0]     din_reg;
    logic [TMR_W-1:0]     tmr_reg [2];
    logic [15:0]          tick_cnt_reg [2];
    logic [1:0]           tick;
    logic [1:0]           wrap;
    logic [1:0]           load;
    logic [15:0]          mask_reg;
    logic                 prot_en_reg;
    logic                 ram_we;
    logic                 ram_rdata;
    logic                 chk_bit;
    iot_wreq_t            wreq_reg;
    logic                 block_now;
    logic                 rd_pend_reg;
    logic [31:0]          rd_mux;

    // one decode used by both the write strobe and the read mux
    function automatic logic is_prot(input logic [11:0] a);
        return (a >= OFS_PROT_BASE) && (a <= OFS_PROT_END);
    endfunction

    // ahb-lite data-phase tracking; a protect ram read waits one extra cycle,
    // since the ram's read register only sees the latched address one edge late
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_reg <= IOT_ST_IDLE;
            ap_reg <= '0;
            rd_pend_reg <= 1'b0;
        end else begin
            case (st_reg)
                IOT_ST_IDLE, IOT_ST_WDATA, IOT_ST_RDATA: begin
                    if (hsel_in && hready_in && htrans_in == HTRANS_NONSEQ) begin
                        ap_reg.write <= hwrite_in;
                        ap_reg.addr  <= {haddr_in[11:2], 2'b00};
                        st_reg <= hwrite_in ? IOT_ST_WDATA : IOT_ST_RWAIT;
                        rd_pend_reg <= !hwrite_in && is_prot({haddr_in[11:2], 2'b00});
                    end else begin
                        st_reg <= IOT_ST_IDLE;
                    end
                end
                IOT_ST_RWAIT: begin
                    rd_pend_reg <= 1'b0;
                    if (!rd_pend_reg) begin
                        st_reg <= IOT_ST_RDATA;
                    end
                end
                default: st_reg <= IOT_ST_IDLE;
            endcase
        end
    end

    wire wr_now = (st_reg == IOT_ST_WDATA);
    assign ram_we = wr_now && is_prot(ap_reg.addr);

    // hready low in read waits: one for registers, two for the protect ram
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end else begin
            hreadyout_out <= !((hsel_in && hready_in && htrans_in == HTRANS_NONSEQ
                                && !hwrite_in && st_reg != IOT_ST_RWAIT)
                               || (st_reg == IOT_ST_RWAIT && rd_pend_reg));
            hresp_out     <= 1'b0;
        end
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (ap_reg.addr)
            OFS_DOUT:      rd_mux = {26'h0, dout_reg};
            OFS_DIN:       rd_mux = {24'h0, din_reg};
            OFS_TMR1:      rd_mux = {16'h0, tmr_reg[0]};
            OFS_TMR2:      rd_mux = {16'h0, tmr_reg[1]};
            OFS_MASK:      rd_mux = {16'h0, mask_reg};
            OFS_PROT_CTRL: rd_mux = {31'h0, prot_en_reg};
            default:       rd_mux = is_prot(ap_reg.addr) ? {31'h0, ram_rdata} : 32'h0;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            hrdata_out <= 32'h0000_0000;
        end else if (st_reg == IOT_ST_RWAIT && !rd_pend_reg) begin
            hrdata_out <= rd_mux;
        end
    end

    // discrete output holding register
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dout_reg <= DOUT_RST;
        end else if (wr_now && ap_reg.addr == OFS_DOUT) begin
            dout_reg <= hwdata_in[DOUT_W-1:0];
        end
    end
    assign bus_interface_unit_dout_out = dout_reg;

    // two-stage sync; only the second stage is read
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            din_meta_reg <= '0;
            din_reg      <= '0;
        end else begin
            din_meta_reg <= bus_interface_unit_din_in;
            din_reg      <= din_meta_reg;
        end
    end

    // mask and protection enable
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mask_reg    <= MASK_RST;
            prot_en_reg <= 1'b0;
        end else begin
            if (wr_now && ap_reg.addr == OFS_MASK) begin
                mask_reg <= hwdata_in[15:0];
            end
            if (wr_now && ap_reg.addr == OFS_PROT_CTRL) begin
                prot_en_reg <= hwdata_in[0];
            end
        end
    end

    // timers: prescaler plus 16-bit counter each
    generate
        for (genvar i = 0; i < 2; i++) begin : g_tmr
            localparam logic [15:0] DIV = (i == 0) ? 16'(TMR1_CYCLES - 1)
                                                   : 16'(TMR2_CYCLES - 1);
            localparam logic [11:0] OFS = (i == 0) ? OFS_TMR1 : OFS_TMR2;
            assign tick[i] = (tick_cnt_reg[i] == DIV);
            assign load[i] = wr_now && ap_reg.addr == OFS;
            assign wrap[i] = tick[i] && !load[i] && tmr_reg[i] == TMR_ONES;

            always_ff @(posedge core_clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    tick_cnt_reg[i] <= 16'h0000;
                end else if (tick[i]) begin
                    tick_cnt_reg[i] <= 16'h0000;
                end else begin
                    tick_cnt_reg[i] <= tick_cnt_reg[i] + 16'h0001;
                end
            end

            // a load wins over a tick; counting resumes from the load value
            always_ff @(posedge core_clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    tmr_reg[i] <= TMR_RST;
                end else if (load[i]) begin
                    tmr_reg[i] <= hwdata_in[15:0];
                end else if (tick[i]) begin
                    tmr_reg[i] <= tmr_reg[i] + 16'h0001;
                end
            end
        end
    endgenerate

    // overflow requests are one-cycle pulses gated by mask
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tmr1_irq_out <= 1'b0;
            tmr2_irq_out <= 1'b0;
        end else begin
            tmr1_irq_out <= wrap[0] && mask_reg[MASK_TMR1_BIT];
            tmr2_irq_out <= wrap[1] && mask_reg[MASK_TMR2_BIT];
        end
    end

    iot_prot_ram u_ram (
        .core_clk_in (core_clk_in),
        .reset_n_in  (reset_n_in),
        .sw_we_in    (ram_we),
        .sw_addr_in  (ap_reg.addr[8:2]),
        .sw_wdata_in (hwdata_in[0]),
        .sw_rdata_out(ram_rdata),
        .chk_addr_in ({mem_wreq_in.dma, mem_wreq_in.addr[15:BLOCK_SHIFT]}),
        .chk_bit_out (chk_bit)
    );

    // check pipeline: request registered alongside ram lookup
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wreq_reg <= '0;
        end else begin
            wreq_reg <= mem_wreq_in;
        end
    end

    // disabled protection means everything blocked, matching power up
    assign block_now = !prot_en_reg || chk_bit;

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mem_we_out    <= 1'b0;
            mem_block_out <= 1'b0;
        end else begin
            mem_we_out    <= wreq_reg.valid && !block_now;
            mem_block_out <= wreq_reg.valid && block_now;
        end
    end

    property p_wrap_irq;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        wrap[1] && mask_reg[MASK_TMR2_BIT] |=> tmr2_irq_out;
    endproperty
    a_wrap_irq: assert property (p_wrap_irq) else $error("timer2 wrap lost");

    property p_masked;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        !$past(mask_reg[MASK_TMR1_BIT]) |-> !tmr1_irq_out;
    endproperty
    a_masked: assert property (p_masked) else $error("masked timer1 irq");

    property p_tick_inc;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        tick[0] && !load[0] |=> tmr_reg[0] == $past(tmr_reg[0]) + 16'h0001;
    endproperty
    a_tick_inc: assert property (p_tick_inc) else $error("timer1 no increment");

    property p_hold;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        !tick[1] && !load[1] |=> $stable(tmr_reg[1]);
    endproperty
    a_hold: assert property (p_hold) else $error("timer2 moved between ticks");

    property p_load;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        load[0] |=> tmr_reg[0] == $past(hwdata_in[15:0]);
    endproperty
    a_load: assert property (p_load) else $error("timer1 load failed");

    property p_block;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        wreq_reg.valid && block_now |=> !mem_we_out && mem_block_out;
    endproperty
    a_block: assert property (p_block) else $error("protected write passed");

    property p_allow;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        wreq_reg.valid && prot_en_reg && !chk_bit |=> mem_we_out;
    endproperty
    a_allow: assert property (p_allow) else $error("allowed write blocked");

    property p_dout;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        wr_now && ap_reg.addr == OFS_DOUT |=> bus_interface_unit_dout_out == $past(hwdata_in[5:0]);
    endproperty
    a_dout: assert property (p_dout) else $error("discrete out not updated");

    sequence s_din_change;
        $changed(bus_interface_unit_din_in);
    endsequence
    property p_din;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        s_din_change |-> ##2 din_reg == $past(bus_interface_unit_din_in, 2);
    endproperty
    a_din: assert property (p_din) else $error("discrete in sync wrong");

    // protect ram read: two low cycles, then ready with the registered bit
    property p_ram_rd_wait;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        st_reg == IOT_ST_RWAIT && rd_pend_reg |=> !hreadyout_out ##1 hreadyout_out;
    endproperty
    a_ram_rd_wait: assert property (p_ram_rd_wait) else $error("ram read wait wrong");

    // every checked write gets exactly one answer two edges after it is taken
    property p_one_answer;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        mem_wreq_in.valid |-> ##2 (mem_we_out ^ mem_block_out);
    endproperty
    a_one_answer: assert property (p_one_answer) else $error("write check answer lost");

    // ticks are far apart, so a wrap request is a single-cycle pulse
    property p_irq_pulse;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        tmr1_irq_out |=> !tmr1_irq_out;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("timer1 request too long");
endmodule // iot_top

// ### tb/iot_bus_unit_model.sv
/*
 * iot_bus_unit_model: far-side model of the bus interface unit and the
 * memory write path; drives discrete inputs and memory write requests.
 * assumes the block answers a write request two edges after taking it.
 */
`timescale 1ns/10ps
module iot_bus_unit_model
    import iot_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        mem_we_in,
    input  wire logic        mem_block_in,
    output logic [DIN_W-1:0] din_out,
    output iot_wreq_t        wreq_out
);
    // idle values before the first request
    initial begin
        din_out = '0;
        wreq_out = '0;
    end

    // discrete lines change right after an edge, as a receiver would
    task automatic set_din(input logic [DIN_W-1:0] v);
        @(posedge core_clk_in);
        din_out <= v;
    endtask

    // one request; the address is scrambled after release so stale data never matches
    task automatic mem_write(input logic dma, input logic [15:0] a,
                             output logic we, output logic blk);
        @(posedge core_clk_in);
        wreq_out <= '{valid: 1'b1, dma: dma, addr: a};
        @(posedge core_clk_in);
        wreq_out <= '{valid: 1'b0, dma: ~dma, addr: ~a};
        repeat (2) @(posedge core_clk_in);
        we = mem_we_in;
        blk = mem_block_in;
    endtask
endmodule // iot_bus_unit_model

// ### tb/testbench.sv
/*
 * testbench: drives iot_top over ahb-lite, compares against a queue and
 * integer model of the discretes, timers and write protection.
 * assumes one 125 MHz clock and a single slave owning hready.
 */
`timescale 1ns/10ps
module testbench
    import iot_pkg::*;
;
    logic              clk, rst_n, hsel, hwrite, hready, hresp, irq1, irq2, mwe, mblk;
    logic [1:0]        htrans;
    logic [2:0]        hsize;
    logic [31:0]       haddr, hwdata, hrdata, seed, r, v;
    logic [DOUT_W-1:0] dout;
    logic [DIN_W-1:0]  din;
    iot_wreq_t         wreq;
    logic              we, blk, eb;
    int                miscompares, compares, cyc, last1, gap1, n, i;
    int                prot_m[128];
    int                en_m;
    int                blocks[$];

    iot_top DUT (.core_clk_in(clk), .reset_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .bus_interface_unit_din_in(din), .bus_interface_unit_dout_out(dout),
        .tmr1_irq_out(irq1), .tmr2_irq_out(irq2), .mem_wreq_in(wreq), .mem_we_out(mwe),
        .mem_block_out(mblk));
    iot_bus_unit_model bum (.core_clk_in(clk), .mem_we_in(mwe), .mem_block_in(mblk),
        .din_out(din), .wreq_out(wreq));

    // free-running clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // spacing of timer one wrap pulses
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (irq1 === 1'b1) begin
            gap1 <= cyc - last1;
            last1 <= cyc;
        end
    end

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one single word transfer; waits on hready with no assumed latency
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {20'h00000, a};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic wait_irq1(input int lim);
        for (int k = 0; k < lim && irq1 !== 1'b1; k++) @(posedge clk);
    endtask

    task automatic conclude();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // watchdog sized at over four times the expected run
    initial begin
        #(8 * 60000);
        miscompares++;
        conclude();
    end

    initial begin
        {rst_n, hsel, hwrite, htrans, haddr, hwdata, cyc, last1, gap1} = '0;
        hsize = 3'h2;
        seed = 32'h1821;
        miscompares = 0;
        compares = 0;
        en_m = 0;
        foreach (prot_m[k]) prot_m[k] = 1;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk(dout, DOUT_RST);
        bum.mem_write(1'b0, 16'h0000, we, blk);
        chk({we, blk}, 2'b01);
        for (i = 0; i < 4; i++) begin
            v = rnd() & 32'h3F;
            wr(OFS_DOUT, v);
            chk(dout, v);
            xfer(1'b0, OFS_DOUT, 0, r);
            chk(r, v);
            chk(hresp, 1'b0);
            v = rnd() & 32'hFF;
            bum.set_din(v[7:0]);
            repeat (3) @(posedge clk);
            xfer(1'b0, OFS_DIN, 0, r);
            chk(r, v);
        end
        $display("discretes done");
        for (i = 0; i < 2; i++) begin
            v = rnd() & 32'hFFF0;
            wr(i ? OFS_TMR2 : OFS_TMR1, v);
            xfer(1'b0, i ? OFS_TMR2 : OFS_TMR1, 0, r);
            if (r === v + 1) r = v;
            chk(r, v);
        end
        wr(OFS_MASK, 32'h1 << MASK_TMR1_BIT);
        wr(OFS_TMR1, TMR_ONES);
        wait_irq1(1300);
        chk(irq1, 1'b1);
        @(posedge clk);
        chk(irq1, 1'b0);
        xfer(1'b0, OFS_TMR1, 0, r);
        chk(r, TMR_RST);
        wr(OFS_TMR1, TMR_ONES);
        @(posedge clk);
        wait_irq1(1300);
        @(posedge clk);
        chk(gap1, TMR1_CYCLES);
        wr(OFS_MASK, 32'h1 << MASK_TMR2_BIT);
        wr(OFS_TMR1, TMR_ONES);
        wr(OFS_TMR2, TMR_ONES);
        n = 0;
        for (i = 0; i < 12700 && irq2 !== 1'b1; i++) begin
            @(posedge clk);
            if (irq1 === 1'b1) n++;
        end
        chk(n, 0);
        chk(irq2, 1'b1);
        $display("timers done");
        xfer(1'b0, 12'h100, 0, r);
        chk(r, 0);
        for (i = 0; i < 12; i++) begin
            n = rnd() % 64;
            blocks.push_back(n);
            prot_m[n] = rnd() & 1;
            prot_m[64 + n] = rnd() & 1;
            wr(OFS_PROT_BASE + 12'(4 * n), prot_m[n]);
            wr(OFS_PROT_BASE + 12'(4 * (64 + n)), prot_m[64 + n]);
            xfer(1'b0, OFS_PROT_BASE + 12'(4 * (64 + n)), 0, r);
            chk(r, prot_m[64 + n]);
            xfer(1'b0, OFS_PROT_BASE + 12'(4 * n), 0, r);
            chk(r, prot_m[n]);
        end
        bum.mem_write(1'b1, 16'(blocks[0] << BLOCK_SHIFT), we, blk);
        chk({we, blk}, 2'b01);
        wr(OFS_PROT_CTRL, 1);
        en_m = 1;
        foreach (blocks[k]) begin
            for (i = 0; i < 4; i++) begin
                v = (blocks[k] << BLOCK_SHIFT) + ((i & 1) ? 1023 : 0);
                eb = (en_m == 0) || (prot_m[(i >> 1) * 64 + blocks[k]] != 0);
                bum.mem_write(i[1], v[15:0], we, blk);
                chk({we, blk}, {~eb, eb});
            end
        end
        $display("protection done");
        conclude();
    end
endmodule // testbench
